// ---- core/can_mob_access.sv ----
// Message-object register access: masks, tags, time stamps and paged data window
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module can_mob_access (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic [mob_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [mob_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_rx_valid,
  input wire logic [28:0] i_rx_id,
  input wire logic i_rx_rtr,
  input wire logic i_rx_ide,
  output logic o_hit,
  output logic [mob_pkg::MOB_W-1:0] o_hit_mob,
  output logic [3:0] o_tx_len
);
  import mob_pkg::*;

  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [MOB_W-1:0] page_mob_q;
  logic [IDX_W-1:0] page_idx_q;
  logic ainc_q;
  logic [15:0] ts_cnt_q;
  logic [31:0] mask_q [MOB_COUNT];
  logic [31:0] tag_q [MOB_COUNT];
  logic [3:0] dlc_q [MOB_COUNT];
  logic [15:0] stamp_q [MOB_COUNT];
  logic [7:0] data_q [MOB_COUNT*BYTES_PER_MOB];

  logic wr_go, rd_go, wr_page, wr_data, rd_data, mob_ok, rd_ok, hit;
  logic [SEL_W-1:0] sel;
  logic [31:0] cur_mask, cur_tag, rd_val, rx_word;
  logic [3:0] cur_dlc;
  logic [15:0] cur_stamp;
  logic [7:0] cur_byte;
  logic [MOB_COUNT-1:0] match;
  logic [MOB_W-1:0] hit_idx;

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == OFF_PAGE) || (a == OFF_MASK) || (a == OFF_TAG) || (a == OFF_DLC) ||
              (a == OFF_STAMP_LO) || (a == OFF_STAMP_HI) || (a == OFF_DATA);
  endfunction

  // Write fires once both address and data are held and the last response is gone
  assign wr_go = !o_awready && !o_wready && !o_bvalid && i_clk_en;
  assign rd_go = o_arready && i_arvalid && i_clk_en;
  assign wr_page = wr_go && (awaddr_q == OFF_PAGE) && wstrb_q[0];
  assign wr_data = wr_go && (awaddr_q == OFF_DATA) && wstrb_q[0] && mob_ok;
  assign rd_data = rd_go && (i_araddr == OFF_DATA);
  // Pages past the last object read as zero and drop writes
  assign mob_ok = (page_mob_q <= MOB_LAST);
  assign sel = {page_mob_q, page_idx_q};
  assign cur_mask = mob_ok ? mask_q[page_mob_q] : '0;
  assign cur_tag = mob_ok ? tag_q[page_mob_q] : '0;
  assign cur_dlc = mob_ok ? dlc_q[page_mob_q] : '0;
  assign cur_stamp = mob_ok ? stamp_q[page_mob_q] : '0;
  assign cur_byte = mob_ok ? data_q[sel] : '0;
  assign rx_word = {i_rx_id, i_rx_rtr, 1'b0, i_rx_ide};

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_awready <= 1'b1;
      awaddr_q <= '0;
    end else if (i_clk_en) begin
      if (o_awready && i_awvalid) begin
        o_awready <= 1'b0;
        awaddr_q <= i_awaddr;
      end else if (wr_go) begin
        o_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wready <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (i_clk_en) begin
      if (o_wready && i_wvalid) begin
        o_wready <= 1'b0;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end else if (wr_go) begin
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (i_clk_en) begin
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    case (i_araddr)
      OFF_PAGE: begin
        rd_val[PAGE_MOB_LSB +: MOB_W] = page_mob_q;
        rd_val[PAGE_AINC_BIT] = ainc_q;
        rd_val[PAGE_IDX_LSB +: IDX_W] = page_idx_q;
      end
      OFF_MASK: rd_val = cur_mask;
      OFF_TAG: rd_val = cur_tag;
      OFF_DLC: begin
        rd_val[3:0] = cur_dlc;
        rd_val[EFF_LEN_LSB +: 4] = eff_len(cur_dlc);
      end
      OFF_STAMP_LO: rd_val[7:0] = cur_stamp[7:0];
      OFF_STAMP_HI: rd_val[7:0] = cur_stamp[15:8];
      OFF_DATA: rd_val[7:0] = cur_byte;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end else if (i_clk_en) begin
      if (rd_go) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_val;
        o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // A page write wins over any increment in the same cycle
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      page_mob_q <= '0;
      page_idx_q <= '0;
      ainc_q <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_page) begin
        page_mob_q <= wdata_q[PAGE_MOB_LSB +: MOB_W];
        page_idx_q <= wdata_q[PAGE_IDX_LSB +: IDX_W];
        ainc_q <= wdata_q[PAGE_AINC_BIT];
      end else if (ainc_q) begin
        page_idx_q <= page_idx_q + IDX_W'(rd_data) + IDX_W'(wr_data);
      end
    end
  end

  // Stored mask and tag keep the reserved bit at zero whatever software writes
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int m = 0; m < MOB_COUNT; m++) begin
        mask_q[m] <= MASK_RESET;
        tag_q[m] <= TAG_RESET;
        dlc_q[m] <= DLC_RESET;
      end
    end else if (i_clk_en && wr_go && mob_ok) begin
      if (awaddr_q == OFF_MASK) begin
        mask_q[page_mob_q] <= merge_strb(mask_q[page_mob_q], wdata_q, wstrb_q);
      end
      if (awaddr_q == OFF_TAG) begin
        tag_q[page_mob_q] <= merge_strb(tag_q[page_mob_q], wdata_q, wstrb_q);
      end
      if ((awaddr_q == OFF_DLC) && wstrb_q[0]) begin
        dlc_q[page_mob_q] <= wdata_q[3:0];
      end
    end
  end

  // Data bytes carry no reset value
  always_ff @(posedge i_core_clk) begin
    if (i_clk_en && wr_data) begin
      data_q[sel] <= wdata_q[7:0];
    end
  end

  for (genvar g = 0; g < MOB_COUNT; g++) begin : g_filt
    mob_accept_filter u_filt (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_mask(mask_q[g]),
      .i_tag(tag_q[g]),
      .i_rx(rx_word),
      .o_match(match[g])
    );
  end

  // Lowest-numbered matching object takes the frame
  always_comb begin
    hit_idx = '0;
    for (int m = MOB_COUNT - 1; m >= 0; m--) begin
      if (match[m]) begin
        hit_idx = MOB_W'(m);
      end
    end
  end
  assign hit = i_rx_valid && (match != '0);

  // Free-running stamp counter; wraps through the full 16-bit range
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ts_cnt_q <= STAMP_RESET;
    end else if (i_clk_en) begin
      ts_cnt_q <= ts_cnt_q + 16'h0001;
    end
  end

  // Stamps are loaded only by accepted frames, never by the bus
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int m = 0; m < MOB_COUNT; m++) begin
        stamp_q[m] <= STAMP_RESET;
      end
    end else if (i_clk_en && hit) begin
      stamp_q[hit_idx] <= ts_cnt_q;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hit <= 1'b0;
      o_hit_mob <= '0;
      o_tx_len <= '0;
    end else if (i_clk_en) begin
      o_hit <= hit;
      if (hit) begin
        o_hit_mob <= hit_idx;
      end
      o_tx_len <= eff_len(cur_dlc);
    end
  end

  stamp_ro_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_go && (awaddr_q == OFF_STAMP_LO || awaddr_q == OFF_STAMP_HI) && !hit) |=> $stable(cur_stamp))
    else $error("time stamp changed by a bus write");
  stamp_wrap_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && ts_cnt_q == STAMP_TOP) |=> (ts_cnt_q == STAMP_RESET))
    else $error("stamp counter did not wrap to zero");
  page_load_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_page |=> (page_idx_q == $past(wdata_q[IDX_W-1:0])) && (page_mob_q == $past(wdata_q[PAGE_MOB_LSB +: MOB_W])))
    else $error("page write not taken as new selection");
  data_read_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    rd_data |=> o_rvalid && (o_rdata == {24'h000000, $past(cur_byte)}))
    else $error("data window read returned wrong byte");
  auto_inc_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (ainc_q && rd_data && !wr_go) |=> (page_idx_q == IDX_W'($past(page_idx_q) + 3'h1)))
    else $error("index did not advance after data access");
  idx_wrap_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (ainc_q && wr_data && !rd_data && page_idx_q == 3'h7) |=> (page_idx_q == 3'h0))
    else $error("index did not wrap from seven to zero");
  len_clamp_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && cur_dlc > DLC_MAX) |=> (o_tx_len == DLC_MAX))
    else $error("length above eight not clamped");
  hit_report_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_clk_en && hit) |=> o_hit && (o_hit_mob == $past(hit_idx)) ##0 (stamp_q[o_hit_mob] == $past(ts_cnt_q)))
    else $error("accepted frame not reported or stamped");

  wrap_seen_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst) ainc_q && wr_data && page_idx_q == 3'h7);
  hit_seen_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst) hit ##1 rd_go);
  burst_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst) rd_data ##[1:4] rd_data);
endmodule

// ---- core/mob_accept_filter.sv ----
// Per-object acceptance comparison of a received identifier word
`timescale 1ns/10ps
module mob_accept_filter (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [31:0] i_mask,
  input wire logic [31:0] i_tag,
  input wire logic [31:0] i_rx,
  output logic o_match
);
  import mob_pkg::*;

  logic [31:0] diff;

  // A clear mask bit forces the compare true; reserved bit 1 never takes part
  assign diff = (i_rx ^ i_tag) & i_mask & MASK_WRITABLE;
  assign o_match = (diff == 32'h0000_0000);

  id_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ((i_mask[31:MASK_ID_LSB] & (i_rx[31:MASK_ID_LSB] ^ i_tag[31:MASK_ID_LSB])) != '0) |-> !o_match)
    else $error("enabled identifier bit mismatch accepted");
  rtr_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_mask[MASK_RTR_BIT] && (i_rx[MASK_RTR_BIT] != i_tag[MASK_RTR_BIT])) |-> !o_match)
    else $error("enabled remote request mismatch accepted");
  ide_mask_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_mask[MASK_IDE_BIT] && (i_rx[MASK_IDE_BIT] != i_tag[MASK_IDE_BIT])) |-> !o_match)
    else $error("enabled extension mismatch accepted");
  // Field-by-field view, so a reserved bit that leaks into the compare is caught
  masked_pass_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (((i_mask[31:MASK_ID_LSB] & (i_rx[31:MASK_ID_LSB] ^ i_tag[31:MASK_ID_LSB])) == '0) &&
     (!i_mask[MASK_RTR_BIT] || (i_rx[MASK_RTR_BIT] == i_tag[MASK_RTR_BIT])) &&
     (!i_mask[MASK_IDE_BIT] || (i_rx[MASK_IDE_BIT] == i_tag[MASK_IDE_BIT]))) |-> o_match)
    else $error("frame rejected although all enabled bits match");
endmodule

// ---- pkg/mob_pkg.sv ----
// Constants and helpers for the message-object access block
package mob_pkg;
  localparam int MOB_COUNT = 6;
  localparam int MOB_W = 3;
  localparam int IDX_W = 3;
  localparam int BYTES_PER_MOB = 8;
  localparam int SEL_W = MOB_W + IDX_W;
  localparam int ADDR_W = 8;
  localparam logic [MOB_W-1:0] MOB_LAST = MOB_W'(MOB_COUNT - 1);

  localparam logic [ADDR_W-1:0] OFF_PAGE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TAG = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DLC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STAMP_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STAMP_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DATA = 8'h18;

  localparam int PAGE_IDX_LSB = 0;
  localparam int PAGE_AINC_BIT = 3;
  localparam int PAGE_MOB_LSB = 4;
  localparam int EFF_LEN_LSB = 8;

  localparam int MASK_ID_LSB = 3;
  localparam int MASK_RTR_BIT = 2;
  localparam int MASK_IDE_BIT = 0;
  // Bit 1 is reserved: stored as zero and excluded from comparison
  localparam logic [31:0] MASK_WRITABLE = 32'hffff_fffd;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] TAG_RESET = 32'h0000_0000;
  localparam logic [3:0] DLC_RESET = 4'h0;
  localparam logic [3:0] DLC_MAX = 4'h8;
  localparam logic [15:0] STAMP_RESET = 16'h0000;
  localparam logic [15:0] STAMP_TOP = 16'hffff;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  function automatic logic [3:0] eff_len(input logic [3:0] dlc);
    eff_len = (dlc > DLC_MAX) ? DLC_MAX : dlc;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    merge_strb = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge_strb[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    merge_strb = merge_strb & MASK_WRITABLE;
  endfunction
endpackage

// ---- test/can_mob_mask_stamp_data_test.sv ----
// Self-checking bench for the message-object access block
`timescale 1ns/10ps
module can_mob_mask_stamp_data_test;
  import mob_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, en = 1'b1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_rtr, rx_ide, hit;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [28:0] rx_id;
  logic [2:0] hit_mob;
  logic [3:0] tx_len;
  logic [15:0] sa, sb;
  int bad_count = 0, tests_run = 0, cyc = 0, ca, cb;
  logic [31:0] mk [8] = '{32'hffff_fffd, 32'hffff_fffd, 32'hffff_fffd, 32'hffff_fffd,
                          32'hffff_fff5, 32'hffff_fff9, 32'hffff_fffc, 32'hffff_fffd};
  logic [31:0] fl [8] = '{32'h0, 32'h8, 32'h4, 32'h1, 32'h8, 32'h4, 32'h1, 32'h8000_0000};
  logic [2:0] em [8] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h1};
  logic [3:0] dl [4] = '{4'h3, 4'h8, 4'h9, 4'hf};

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  can_node_model i_node (.i_core_clk(clk), .o_rx_valid(rx_valid), .o_rx_id(rx_id), .o_rx_rtr(rx_rtr),
                         .o_rx_ide(rx_ide));
  can_mob_access i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_clk_en(en), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_rx_valid(rx_valid), .i_rx_id(rx_id), .i_rx_rtr(rx_rtr), .i_rx_ide(rx_ide),
    .o_hit(hit), .o_hit_mob(hit_mob), .o_tx_len(tx_len));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang(input int n);
    if (n > 64) begin
      bad_count++;
      $display("BAD t=%0t no answer", $time);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        done = 1;
        bready <= 0;
        check({30'h0, bresp}, {30'h0, er});
      end
      hang(n);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        done = 1;
        v = rdata;
        r = rresp;
        rready <= 0;
      end
      hang(n);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [1:0] r;
    rd(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic frame(input logic [31:0] w, input logic [2:0] mob);
    i_node.send(w);
    #1;
    check({31'h0, hit}, 32'h1);
    check({29'h0, hit_mob}, {29'h0, mob});
  endtask

  task automatic stamp(output logic [15:0] s);
    logic [1:0] r;
    rd(OFF_STAMP_LO, d, r);
    s[7:0] = d[7:0];
    rd(OFF_STAMP_HI, d, r);
    s[15:8] = d[7:0];
  endtask

  initial begin
    logic [1:0] r;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(OFF_MASK, MASK_RESET);
    rdc(OFF_DLC, 32'h0);
    rd(8'h1c, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0);
    wr(8'h1c, 32'h1, RESP_SLVERR);
    $display("reset and map test done");
    // Every object accepts while masks are zero; lowest one reports
    frame(32'h1234_5679, 3'h0);
    ca = cyc;
    stamp(sa);
    // Freeze ten edges, then run long enough for the stamp counter to wrap
    @(posedge clk);
    en <= 1'b0;
    repeat (10) @(posedge clk);
    en <= 1'b1;
    repeat (65600) @(posedge clk);
    frame(32'h0000_0000, 3'h0);
    cb = cyc;
    stamp(sb);
    check({16'h0, sb - sa}, {16'h0, 16'(cb - ca - 10)});
    wr(OFF_STAMP_LO, 32'h55, RESP_OKAY);
    rdc(OFF_STAMP_LO, {24'h0, sb[7:0]});
    $display("stamp test done");
    for (int i = 0; i < 8; i++) begin
      wr(OFF_MASK, mk[i], RESP_OKAY);
      wr(OFF_TAG, 32'ha5a5_a5a5, RESP_OKAY);
      rdc(OFF_MASK, mk[i]);
      frame(32'ha5a5_a5a5 ^ fl[i], em[i]);
    end
    $display("mask test done");
    wr(OFF_PAGE, 32'h2e, RESP_OKAY);
    wr(OFF_DATA, 32'h11, RESP_OKAY);
    wr(OFF_DATA, 32'h22, RESP_OKAY);
    wr(OFF_DATA, 32'h33, RESP_OKAY);
    rdc(OFF_PAGE, 32'h29);
    wr(OFF_PAGE, 32'h2e, RESP_OKAY);
    rdc(OFF_DATA, 32'h11);
    rdc(OFF_DATA, 32'h22);
    rdc(OFF_DATA, 32'h33);
    wr(OFF_PAGE, 32'h27, RESP_OKAY);
    rdc(OFF_DATA, 32'h22);
    rdc(OFF_DATA, 32'h22);
    wr(OFF_PAGE, 32'h20, RESP_OKAY);
    rdc(OFF_DATA, 32'h33);
    $display("data window test done");
    foreach (dl[i]) begin
      wr(OFF_DLC, {28'h0, dl[i]}, RESP_OKAY);
      rdc(OFF_DLC, {20'h0, (dl[i] > 4'h8) ? 4'h8 : dl[i], 4'h0, dl[i]});
      check({28'h0, tx_len}, {28'h0, (dl[i] > 4'h8) ? 4'h8 : dl[i]});
    end
    $display("length test done");
    // Mid-run reset puts page and length back to their reset values
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    rdc(OFF_PAGE, 32'h0);
    rdc(OFF_DLC, 32'h0);
    check({28'h0, tx_len}, 32'h0);
    $display("reset again test done");
    give_verdict();
  end
endmodule

// ---- test/can_node_model.sv ----
// Far-side node model: presents received frame headers to the block
`timescale 1ns/10ps
module can_node_model (
  input wire logic i_core_clk,
  output logic o_rx_valid,
  output logic [28:0] o_rx_id,
  output logic o_rx_rtr,
  output logic o_rx_ide
);
  initial begin
    o_rx_valid = 1'b0;
    o_rx_id = '0;
    o_rx_rtr = 1'b0;
    o_rx_ide = 1'b0;
  end

  // Word layout as in the tag register: id at 31:3, rtr at 2, ide at 0
  task automatic send(input logic [31:0] w);
    @(posedge i_core_clk);
    o_rx_valid <= 1'b1;
    o_rx_id <= w[31:3];
    o_rx_rtr <= w[2];
    o_rx_ide <= w[0];
    @(posedge i_core_clk);
    // Header is stale after the pulse, so show its inverse
    o_rx_valid <= 1'b0;
    o_rx_id <= ~w[31:3];
    o_rx_rtr <= ~w[2];
    o_rx_ide <= ~w[0];
  endtask
endmodule
